// ---- core/charger_status_irq_bank.v ----
// Purpose: Status, event enables and interrupt pin of the charger unit
// Assumes: Status inputs come from analog logic; all are synchronised
//          here. Register port is a simple 8-bit read/write strobe port.
// Notes:   Open-drain pins use separate output and output enable.
//          Edge events are held off until the edge history is filled,
//          so pins idling high give no false edge after reset.
`timescale 1ns/1ps
`include "charger_status_irq_consts.vh"

module charger_status_irq_bank #(
  parameter RESET_DELAY_CYCLES = `RESET_DELAY_CYC
) (
  input  wire       i_clock,
  input  wire       i_rst_b,
  input  wire       i_battery_temp_valid,
  input  wire       i_input_present,
  input  wire [1:0] i_charging_phase,
  input  wire       i_supply_type_pin,
  input  wire       i_precondition_timeout,
  input  wire       i_total_timeout,
  input  wire       i_supplies_good,
  input  wire [7:0] i_reg_addr,
  input  wire [7:0] i_reg_wdata,
  input  wire       i_reg_write,
  input  wire       i_reg_read,
  output reg  [7:0] o_reg_rdata,
  output wire       o_interrupt_out_n,
  output wire       o_interrupt_out_n_oe,
  output wire       o_reset_out_n,
  output wire       o_reset_out_n_oe
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  localparam SYNC_W = 7;
  wire [SYNC_W-1:0] raw_in;
  reg  [SYNC_W-1:0] sync1_reg;
  reg  [SYNC_W-1:0] sync2_reg;
  reg  [SYNC_W-1:0] prev_reg;

  // Bit order of the synchronised bundle: 6 supplies good,
  // 5 total timeout, 4 precondition timeout, 3 supply type,
  // 2:1 charging phase, 0 battery temperature
  assign raw_in = {i_supplies_good, i_total_timeout, i_precondition_timeout,
                   i_supply_type_pin, i_charging_phase[1],
                   i_charging_phase[0], i_battery_temp_valid};

  // Input present is carried separately so its edges are visible
  reg in_s1_reg;
  reg in_s2_reg;
  reg in_prev_reg;

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g = g + 1) begin : g_sync
      always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
          prev_reg[g]  <= 1'b0;
        end else begin
          sync1_reg[g] <= raw_in[g];
          sync2_reg[g] <= sync1_reg[g];
          prev_reg[g]  <= sync2_reg[g];
        end
      end
    end
  endgenerate

  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      in_s1_reg   <= 1'b0;
      in_s2_reg   <= 1'b0;
      in_prev_reg <= 1'b0;
    end else begin
      in_s1_reg   <= i_input_present;
      in_s2_reg   <= in_s1_reg;
      in_prev_reg <= in_s2_reg;
    end
  end

  wire       temp_ok    = sync2_reg[0];
  wire [1:0] phase      = sync2_reg[2:1];
  wire [1:0] phase_prev = prev_reg[2:1];
  wire       supply_hi  = sync2_reg[3];
  wire       pre_to     = sync2_reg[4];
  wire       tot_to     = sync2_reg[5];
  wire       sup_good   = sync2_reg[6];

  // ************************************************************
  // Decoding
  // ************************************************************
  function is_end_charge;
    input [1:0] p;
    begin
      is_end_charge = (p == `PHASE_END_CHARGE);
    end
  endfunction

  // Register address match, shared by the three access strobes
  function addr_is;
    input [7:0] a;
    input [7:0] target;
    begin
      addr_is = (a == target);
    end
  endfunction

  wire eoc_now  = is_end_charge(phase);
  wire eoc_prev = is_end_charge(phase_prev);

  // Temperature and charge edges are ignored unless supplies good is high in both samples
  wire ev_ok = sup_good & prev_reg[6];

  // ************************************************************
  // Edge-detect warm-up
  // ************************************************************
  // The edge history clears to 0 while pins may idle high, so the first
  // cycles after reset would show false rising edges. Edges count only
  // once the history stage holds real samples.
  localparam WARM_W = `SYNC_SETTLE;
  reg  [WARM_W-1:0] warm_reg;
  wire              armed = warm_reg[WARM_W-1];

  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      warm_reg <= {WARM_W{1'b0}};
    end else begin
      warm_reg <= {warm_reg[WARM_W-2:0], 1'b1};
    end
  end

  // ************************************************************
  // Edge detection
  // ************************************************************
  // Each edge compares the synchronised sample with the one before it
  wire temp_rise = armed & temp_ok & ~prev_reg[0];
  wire temp_fall = armed & ~temp_ok & prev_reg[0];
  wire in_rise   = armed & in_s2_reg & ~in_prev_reg;
  wire in_fall   = armed & ~in_s2_reg & in_prev_reg;
  wire eoc_rise  = armed & eoc_now & ~eoc_prev;
  wire eoc_fall  = armed & ~eoc_now & eoc_prev;
  wire pre_rise  = armed & pre_to & ~prev_reg[4];
  wire tot_rise  = armed & tot_to & ~prev_reg[5];

  // ************************************************************
  // Registers
  // ************************************************************
  reg  [7:0] enables_reg;
  reg  [3:0] groups_reg;     // Enable bits written by software
  reg  [3:0] pending_reg;
  reg  [3:0] pending_next;
  // Timer status is a plain level, one cycle behind its inputs
  reg        timer_stat_reg;

  wire wr_flags   = i_reg_write & addr_is(i_reg_addr, `ADDR_FLAGS);
  wire wr_enables = i_reg_write & addr_is(i_reg_addr, `ADDR_ENABLES);
  wire rd_flags   = i_reg_read  & addr_is(i_reg_addr, `ADDR_FLAGS);

  // Event detection, per group: timer, temperature, input, charge
  // An event needs both its own enable bit and its group bit
  wire ev_timer = (enables_reg[`BIT_TOTAL_TO] & tot_rise)
                | (enables_reg[`BIT_PRE_TO] & pre_rise);
  wire ev_temp  = ev_ok &
                  ((enables_reg[`BIT_TEMP_ENTER] & temp_rise)
                 | (enables_reg[`BIT_TEMP_LEAVE] & temp_fall));
  wire ev_input = (enables_reg[`BIT_INPUT_CONNECT] & in_rise)
                | (enables_reg[`BIT_INPUT_DROP] & in_fall);
  wire ev_chg   = ev_ok &
                  ((enables_reg[`BIT_DONE_ENTER] & eoc_rise)
                 | (enables_reg[`BIT_DONE_EXIT] & eoc_fall));
  wire [3:0] events = {ev_timer, ev_temp, ev_input, ev_chg} & groups_reg;

  // A read clears pending, but an event in the same cycle wins
  always @* begin
    pending_next = pending_reg;
    if (rd_flags) begin
      pending_next = `RESET_GROUPS;
    end
    pending_next = pending_next | events;
  end

  // Software-written enables; the group bits share the flag address
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      enables_reg <= `RESET_BYTE;
      groups_reg  <= `RESET_GROUPS;
    end else begin
      if (wr_enables) begin
        enables_reg <= i_reg_wdata;
      end
      if (wr_flags) begin
        groups_reg <= i_reg_wdata[`BIT_TIMER_GRP:`BIT_CHARGE_GRP];
      end
    end
  end

  // Clearing a group bit leaves an already pending flag in place, so
  // software never loses an event by masking it late
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pending_reg    <= `RESET_GROUPS;
      timer_stat_reg <= 1'b0;
    end else begin
      pending_reg    <= pending_next;
      timer_stat_reg <= pre_to | tot_to;
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  reg [7:0] rdata_next;
  always @* begin
    rdata_next = `RESET_BYTE;
    case (i_reg_addr)
      `ADDR_FLAGS: begin
        // Group bits read back the pending flags
        rdata_next[`BIT_TIMER_GRP:`BIT_CHARGE_GRP] = pending_reg;
        rdata_next[`BIT_TIMER_STAT]    = timer_stat_reg;
        rdata_next[`BIT_TEMP_VALID]    = temp_ok;
        rdata_next[`BIT_INPUT_PRESENT] = in_s2_reg;
        rdata_next[`BIT_END_OF_CHARGE] = eoc_now;
      end
      `ADDR_ENABLES: begin
        rdata_next = enables_reg;
      end
      `ADDR_STATE_REPORT: begin
        rdata_next[`PHASE_HI:`PHASE_LO] = phase;
        rdata_next[`BIT_SUPPLY_TYPE]    = supply_hi;
      end
      default: begin
        rdata_next = `RESET_BYTE;
      end
    endcase
  end

  // Read data is captured only on a read strobe and then stands
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= `RESET_BYTE;
    end else if (i_reg_read) begin
      o_reg_rdata <= rdata_next;
    end
  end

  // ************************************************************
  // Interrupt pin, open drain: driven low while any flag pends
  // ************************************************************
  // The pin only pulls low; the board pull-up gives the idle level
  assign o_interrupt_out_n    = 1'b0;
  assign o_interrupt_out_n_oe = |pending_reg;

  // ************************************************************
  // Reset output release delay
  // ************************************************************
  // Nominal 64 ms count lies inside the allowed 88 to 112 percent band.
  // The band is wide, so no trim of the count is offered; a faster
  // clock needs RESET_DELAY_CYCLES scaled within the 23-bit counter.
  localparam CNT_W = 23;
  localparam [31:0]      DELAY_FULL = RESET_DELAY_CYCLES - 1;
  localparam [CNT_W-1:0] DELAY_LAST = DELAY_FULL[CNT_W-1:0];
  reg [CNT_W-1:0] delay_cnt_reg;
  reg             released_reg;

  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      delay_cnt_reg <= {CNT_W{1'b0}};
      released_reg  <= 1'b0;
    end else if (!released_reg) begin
      if (delay_cnt_reg == DELAY_LAST) begin
        released_reg <= 1'b1;
      end else begin
        delay_cnt_reg <= delay_cnt_reg + 1'b1;
      end
    end
  end

  assign o_reset_out_n    = 1'b0;
  assign o_reset_out_n_oe = ~released_reg;

endmodule

// ---- core/charger_status_irq_consts.vh ----
// Purpose: Constants for the charger status and interrupt register bank
// Assumes: 8-bit registers reached on a plain register port
// Notes:   Included by charger_status_irq_bank.v
`ifndef CHARGER_STATUS_IRQ_CONSTS_VH
`define CHARGER_STATUS_IRQ_CONSTS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define ADDR_FLAGS        8'h78
`define ADDR_ENABLES      8'h79
`define ADDR_STATE_REPORT 8'h7a

// ************************************************************
// Fields of the status and flag register
// ************************************************************
`define BIT_TIMER_GRP     7
`define BIT_TEMP_GRP      6
`define BIT_INPUT_GRP     5
`define BIT_CHARGE_GRP    4
`define BIT_TIMER_STAT    3
`define BIT_TEMP_VALID    2
`define BIT_INPUT_PRESENT 1
`define BIT_END_OF_CHARGE 0

// ************************************************************
// Fields of the event enable register
// ************************************************************
`define BIT_TOTAL_TO      7
`define BIT_TEMP_ENTER    6
`define BIT_INPUT_CONNECT 5
`define BIT_DONE_ENTER    4
`define BIT_PRE_TO        3
`define BIT_TEMP_LEAVE    2
`define BIT_INPUT_DROP    1
`define BIT_DONE_EXIT     0

// ************************************************************
// Fields of the state report register
// ************************************************************
`define PHASE_HI          5
`define PHASE_LO          4
`define BIT_SUPPLY_TYPE   1

// ************************************************************
// Reset values and phase encoding
// ************************************************************
`define RESET_BYTE        8'h00
`define RESET_GROUPS      4'h0
`define PHASE_END_CHARGE  2'h3
`define SYNC_SETTLE       3

// ************************************************************
// Reset-output release delay
// ************************************************************
`define CLOCK_HZ          100000000
`define RESET_DELAY_MS    64
`define RESET_DELAY_CYC   (`RESET_DELAY_MS * (`CLOCK_HZ / 1000))

`endif

// ---- tb/charger_status_irq_bank_properties.sv ----
// Purpose: Port-level checks of the charger status and interrupt bank
// Assumes: Status inputs held still between register reads
// Notes:   Status checks wait for four calm cycles on every input
`timescale 1ns/1ps
module charger_status_irq_bank_properties #(
  parameter RESET_DELAY_CYCLES = 20
) (
  input wire       i_clock,
  input wire       i_rst_b,
  input wire       i_battery_temp_valid,
  input wire       i_input_present,
  input wire [1:0] i_charging_phase,
  input wire       i_supply_type_pin,
  input wire       i_precondition_timeout,
  input wire       i_total_timeout,
  input wire       i_supplies_good,
  input wire [7:0] i_reg_addr,
  input wire       i_reg_read,
  input wire [7:0] o_reg_rdata,
  input wire       o_interrupt_out_n_oe,
  input wire       o_reset_out_n_oe
);
  wire [7:0] ins = {i_supplies_good, i_supply_type_pin, i_total_timeout,
                    i_precondition_timeout, i_charging_phase,
                    i_input_present, i_battery_temp_valid};
  reg  [7:0] prev_reg;
  reg  [2:0] calm_reg;
  reg [31:0] since_reg;
  // Sync plus edge detect take 3 cycles, so 4 calm cycles leave margin
  wire       quiet = calm_reg[2];
  wire       rd78 = quiet && i_reg_read && i_reg_addr == 8'h78;
  wire       rd7a = quiet && i_reg_read && i_reg_addr == 8'h7a;
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_reg <= 8'h00;
      calm_reg <= 3'h0;
      since_reg <= 32'h0;
    end else begin
      prev_reg <= ins;
      if (ins != prev_reg)
        calm_reg <= 3'h0;
      else if (!quiet)
        calm_reg <= calm_reg + 3'h1;
      if (since_reg < RESET_DELAY_CYCLES)
        since_reg <= since_reg + 32'h1;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  property p_temp;
    rd78 && i_supplies_good
      |=> o_reg_rdata[2] == $past(i_battery_temp_valid);
  endproperty
  a_temp: assert property (p_temp)
    else $error("temperature bit wrong");
  property p_inp;
    rd78 |=> o_reg_rdata[1] == $past(i_input_present);
  endproperty
  a_inp: assert property (p_inp)
    else $error("input bit wrong");
  property p_eoc;
    rd78 && i_supplies_good
      |=> o_reg_rdata[0] == ($past(i_charging_phase) == 2'h3);
  endproperty
  a_eoc: assert property (p_eoc)
    else $error("end of charge bit wrong");
  property p_tmr;
    rd78 |=> o_reg_rdata[3] ==
      $past(i_precondition_timeout | i_total_timeout);
  endproperty
  a_tmr: assert property (p_tmr)
    else $error("timer bit wrong");
  property p_rep;
    rd7a |=> o_reg_rdata[5:4] == $past(i_charging_phase) &&
      {o_reg_rdata[7:6], o_reg_rdata[3:2], o_reg_rdata[0]} == 5'h00;
  endproperty
  a_rep: assert property (p_rep)
    else $error("state report wrong");
  property p_sup;
    rd7a |=> o_reg_rdata[1] == $past(i_supply_type_pin);
  endproperty
  a_sup: assert property (p_sup)
    else $error("supply type bit wrong");
  property p_clr;
    rd78 |=> !o_interrupt_out_n_oe;
  endproperty
  a_clr: assert property (p_clr)
    else $error("interrupt not released by read");
  property p_idle;
    quiet && !o_interrupt_out_n_oe |=> $stable(o_interrupt_out_n_oe);
  endproperty
  a_idle: assert property (p_idle)
    else $error("interrupt without event");
  property p_rst;
    o_reset_out_n_oe == (since_reg < RESET_DELAY_CYCLES);
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset output delay wrong");
endmodule

// ---- tb/charger_status_irq_bank_tb.sv ----
// Purpose: Random self-checking bench for the charger status bank
// Assumes: Short reset delay parameter
// Notes:   Status bits 2 and 0 are masked while supplies are bad
`timescale 1ns/1ps
module charger_status_irq_bank_tb;
  localparam DLY = 20;
  reg        i_clock = 0;
  reg        i_rst_b = 0;
  reg  [7:0] drv = 8'h80;
  reg  [7:0] addr = 0;
  reg  [7:0] wd = 0;
  reg        wr_s = 0;
  reg        rd_s = 0;
  reg [31:0] seed = 32'h2116;
  reg  [7:0] en, grp, got, s, e, m;
  wire [7:0] rdata;
  wire       irq_oe, rst_oe, irq_pin, rst_pin;
  integer    n_fail = 0, compares = 0, k;
  charger_status_irq_bank #(.RESET_DELAY_CYCLES(DLY))
    i_charger_status_irq_bank (
    .i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_battery_temp_valid(drv[0]), .i_input_present(drv[1]),
    .i_charging_phase(drv[3:2]), .i_precondition_timeout(drv[4]),
    .i_total_timeout(drv[5]), .i_supply_type_pin(drv[6]),
    .i_supplies_good(drv[7]), .i_reg_addr(addr), .i_reg_wdata(wd),
    .i_reg_write(wr_s), .i_reg_read(rd_s), .o_reg_rdata(rdata),
    .o_interrupt_out_n(irq_pin), .o_interrupt_out_n_oe(irq_oe),
    .o_reset_out_n(rst_pin), .o_reset_out_n_oe(rst_oe));
  function [31:0] nx();
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      nx = seed;
    end
  endfunction
  // Expected flag byte after inputs move from o to n with no read between
  function [7:0] want(input [7:0] o, input [7:0] n);
    reg       ok;
    reg [3:0] ev;
    begin
      ok = o[7] & n[7];
      ev[3] = en[3] & n[4] & !o[4] | en[7] & n[5] & !o[5];
      ev[2] = ok & (en[6] & n[0] & !o[0] | en[2] & o[0] & !n[0]);
      ev[1] = en[5] & n[1] & !o[1] | en[1] & o[1] & !n[1];
      ev[0] = ok & (en[4] & &n[3:2] & !(&o[3:2])
              | en[0] & &o[3:2] & !(&n[3:2]));
      want = {ev & grp[7:4], n[4] | n[5], n[0], n[1], &n[3:2]};
    end
  endfunction
  task chk(input string nm, input [7:0] x, input [7:0] g);
    begin
      compares = compares + 1;
      if (g !== x) begin
        n_fail = n_fail + 1;
        $display("mismatch %0s exp %h got %h", nm, x, g);
      end
    end
  endtask
  task acc(input w, input [7:0] a, input [7:0] d);
    begin
      @(negedge i_clock);
      addr = a;
      wd = d;
      wr_s = w;
      rd_s = !w;
      @(negedge i_clock);
      wr_s = 0;
      rd_s = 0;
      got = rdata;
    end
  endtask
  task conclude;
    begin
      if (n_fail == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  always #5 i_clock = ~i_clock;
  initial begin
    #100000;
    n_fail = n_fail + 1;
    conclude;
  end
  initial begin
    repeat (16) @(negedge i_clock);
    i_rst_b = 1;
    chk("rst_oe", 1, rst_oe);
    repeat (DLY) @(negedge i_clock);
    chk("rst_oe", 0, rst_oe);
    acc(0, 8'h79, 0);
    chk("enables", 0, got);
    for (k = 0; k < 60; k = k + 1) begin
      en = (k < 2) ? 8'hff : nx();
      grp = (k < 2) ? 8'hf0 : nx();
      acc(1, 8'h79, en);
      acc(1, 8'h78, grp);
      acc(0, 8'h79, 0);
      chk("enables", en, got);
      s = nx();
      s[7] = s[7] | (k < 4);
      e = want(drv, s);
      m = s[7] ? 8'hff : 8'hfa;
      drv = s;
      repeat (6) @(negedge i_clock);
      chk("irq_oe", |e[7:4], irq_oe);
      acc(0, 8'h78, 0);
      chk("flags", e & m, got & m);
      chk("irq_oe", 0, irq_oe);
      acc(0, 8'h7a, 0);
      chk("report", {2'h0, s[3:2], 2'h0, s[6], 1'h0}, got);
    end
    acc(1, 8'h7a, 8'hff);
    acc(0, 8'h7a, 0);
    chk("report", {2'h0, drv[3:2], 2'h0, drv[6], 1'h0}, got);
    acc(0, 8'h7b, 0);
    chk("unmapped", 0, got);
    chk("irq_pin", 0, irq_pin);
    chk("rst_pin", 0, rst_pin);
    conclude;
  end
endmodule
bind charger_status_irq_bank charger_status_irq_bank_properties
  #(.RESET_DELAY_CYCLES(RESET_DELAY_CYCLES))
  i_charger_status_irq_bank_properties (.*);
